// [common/crw_pkg.sv]
/*
 * Constants shared by the chip reset watchdog: register indices, field
 * positions, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus whose byte address is four times
 * the register index.
 */
package crw_pkg;

    // Bus geometry.
    localparam int          ADDR_W      = 18;
    localparam int          DATA_W      = 32;
    localparam int          STRB_W      = 4;
    localparam int          IDX_W       = 16;

    // Register indices; the byte address is the index shifted left by two.
    localparam logic [15:0] IDX_CONTROL    = 16'hf020;
    localparam logic [15:0] IDX_LIVE_COUNT = 16'hf021;
    localparam logic [15:0] IDX_WRAP_VALUE = 16'hf022;
    localparam logic [15:0] IDX_DOWN_COUNT = 16'hf023;
    localparam logic [15:0] IDX_TRIGGERED  = 16'hf024;
    localparam logic [15:0] IDX_EVT_STATUS = 16'hf025;
    localparam logic [15:0] IDX_EVT_MASK   = 16'hf026;
    localparam logic [1:0]  ADDR_LSB_ZERO  = 2'h0;

    // Field positions.
    localparam int          CTRL_COUNT_EN = 0;
    localparam int          CTRL_RESET_EN = 1;
    localparam int          CTRL_W        = 2;
    localparam int          TRIG_FLAG     = 0;
    localparam int          EVT_TIMEOUT   = 0;
    localparam int          EVT_WRAP      = 1;
    localparam int          EVT_W         = 2;

    // Counter widths and reset values.
    localparam int          PRESCALE_W    = 16;
    localparam int          COUNT_W       = 12;
    localparam int          FIELD_MAX_W   = 16;
    localparam logic [15:0] WRAP_RESET    = 16'hffff;
    localparam logic [15:0] COUNT_RESET   = 16'h0fff;

    // AXI responses.
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// [rtl/crw_counter.sv]
/*
 * Prescaler and timeout down-counter of the chip reset watchdog.
 * Assumes tick is a one-cycle pulse per crystal rising edge, already synchronised
 * to aclk, and that load has priority over counting.
 */
`timescale 1ns/1ps

module crw_counter #(
    parameter int PRESCALE_W = 16,
    parameter int COUNT_W    = 12
) (
    // Clock and reset.
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Control.
    input  wire logic                  tick,
    input  wire logic                  count_en,
    input  wire logic [PRESCALE_W-1:0] wrap_value,
    input  wire logic                  load,
    input  wire logic [COUNT_W-1:0]    load_value,
    // State.
    output logic      [PRESCALE_W-1:0] prescale,
    output logic      [COUNT_W-1:0]    down_count,
    output logic                       wrap_pulse
);

    logic                  step;
    logic                  at_wrap;
    logic                  at_zero;
    logic [PRESCALE_W-1:0] next_prescale;
    logic [COUNT_W-1:0]    next_down_count;

    assign step    = tick & count_en;
    assign at_wrap = (prescale == wrap_value);
    assign at_zero = (down_count == '0);

    assign next_prescale = !step ? prescale :
                           at_wrap ? '0 : prescale + PRESCALE_W'(1);

    // decrement once per wrap, stopping at zero
    assign next_down_count = load ? load_value :
                             (step && at_wrap && !at_zero) ? down_count - COUNT_W'(1) :
                             down_count;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prescale   <= '0;
            down_count <= crw_pkg::COUNT_RESET[COUNT_W-1:0];
            wrap_pulse <= 1'b0;
        end
        else
        begin
            prescale   <= next_prescale;
            down_count <= next_down_count;
            wrap_pulse <= step & at_wrap;
        end
    end

endmodule

// [rtl/crw_top.sv]
/*
 * Chip reset watchdog: AXI4-Lite register slave, crystal input
 * synchroniser, timeout reset request and event interrupt.
 * Assumes aresetn is the power-on reset only, and that the crystal input
 * toggles slower than half the aclk rate.
 */
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps

module crw_top #(
    parameter int PRESCALE_W = crw_pkg::PRESCALE_W,
    parameter int COUNT_W    = crw_pkg::COUNT_W
) (
    // Clock and power-on reset.
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite write address.
    input  wire logic [crw_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    // AXI4-Lite write data.
    input  wire logic [crw_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [crw_pkg::STRB_W-1:0]  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // AXI4-Lite read address.
    input  wire logic [crw_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    // AXI4-Lite read data.
    output logic [crw_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Crystal oscillator pin.
    input  wire logic                        crystal_input,
    // Chip reset request and interrupt.
    output logic                             chip_reset_out,
    output logic                             irq
);

    generate
        if (PRESCALE_W < 1 || PRESCALE_W > crw_pkg::FIELD_MAX_W ||
            COUNT_W < 1 || COUNT_W > crw_pkg::FIELD_MAX_W)
        begin : g_bad_width
            $error("crw_top: counter widths must lie between 1 and 16");
        end
    endgenerate

    // Register byte addresses.
    localparam logic [crw_pkg::ADDR_W-1:0] A_CONTROL =
        {crw_pkg::IDX_CONTROL, crw_pkg::ADDR_LSB_ZERO};
    localparam logic [crw_pkg::ADDR_W-1:0] A_LIVE =
        {crw_pkg::IDX_LIVE_COUNT, crw_pkg::ADDR_LSB_ZERO};
    localparam logic [crw_pkg::ADDR_W-1:0] A_WRAP =
        {crw_pkg::IDX_WRAP_VALUE, crw_pkg::ADDR_LSB_ZERO};
    localparam logic [crw_pkg::ADDR_W-1:0] A_COUNT =
        {crw_pkg::IDX_DOWN_COUNT, crw_pkg::ADDR_LSB_ZERO};
    localparam logic [crw_pkg::ADDR_W-1:0] A_TRIG =
        {crw_pkg::IDX_TRIGGERED, crw_pkg::ADDR_LSB_ZERO};
    localparam logic [crw_pkg::ADDR_W-1:0] A_EVT =
        {crw_pkg::IDX_EVT_STATUS, crw_pkg::ADDR_LSB_ZERO};
    localparam logic [crw_pkg::ADDR_W-1:0] A_MASK =
        {crw_pkg::IDX_EVT_MASK, crw_pkg::ADDR_LSB_ZERO};

    // Merges write data into an old value under the byte strobes.
    function automatic logic [crw_pkg::DATA_W-1:0] merge(
        input logic [crw_pkg::DATA_W-1:0] old,
        input logic [crw_pkg::DATA_W-1:0] data,
        input logic [crw_pkg::STRB_W-1:0] strb
    );
        logic [crw_pkg::DATA_W-1:0] res;
        res = old;
        for (int i = 0; i < crw_pkg::STRB_W; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = data[i*8 +: 8];
        end
        return res;
    endfunction

    // Write and read channel state.
    logic                          aw_have;
    logic [crw_pkg::ADDR_W-1:0]    aw_addr;
    logic                          w_have;
    logic [crw_pkg::DATA_W-1:0]    w_data;
    logic [crw_pkg::STRB_W-1:0]    w_strb;
    logic                          aw_take;
    logic                          w_take;
    logic                          do_write;
    logic                          next_aw_have;
    logic                          next_w_have;
    logic                          next_bvalid;
    logic                          ar_take;
    logic                          next_rvalid;

    // Register state.
    logic [crw_pkg::CTRL_W-1:0]    control;
    logic [PRESCALE_W-1:0]         wrap_value;
    logic                          triggered;
    logic [crw_pkg::EVT_W-1:0]     evt_status;
    logic [crw_pkg::EVT_W-1:0]     evt_mask;

    // Counter core.
    logic [PRESCALE_W-1:0]         prescale;
    logic [COUNT_W-1:0]            down_count;
    logic                          wrap_pulse;

    // Crystal synchroniser and edge detect.
    logic                          xin_meta;
    logic                          xin_sync;
    logic                          xin_last;
    logic                          xin_tick;

    logic                          count_en;
    logic                          reset_en;
    logic                          at_zero;
    logic                          zero_last;
    logic                          next_chip_reset;
    logic [crw_pkg::EVT_W-1:0]     evt_set;
    logic [crw_pkg::EVT_W-1:0]     evt_clr;
    logic [crw_pkg::EVT_W-1:0]     next_evt_status;

    // Write decode.
    logic                          wsel_control;
    logic                          wsel_wrap;
    logic                          wsel_count;
    logic                          wsel_evt;
    logic                          wsel_mask;
    logic                          wsel_ro;
    logic                          wsel_ok;
    logic [crw_pkg::DATA_W-1:0]    wr_control;
    logic [crw_pkg::DATA_W-1:0]    wr_wrap;
    logic [crw_pkg::DATA_W-1:0]    wr_count;
    logic [crw_pkg::DATA_W-1:0]    wr_evt;
    logic [crw_pkg::DATA_W-1:0]    wr_mask;

    // Read decode.
    logic                          rsel_ok;
    logic [crw_pkg::DATA_W-1:0]    rd_data;

    assign aw_take      = s_axi_awvalid & s_axi_awready;
    assign w_take       = s_axi_wvalid & s_axi_wready;
    assign do_write     = aw_have & w_have & ~s_axi_bvalid;
    assign next_aw_have = (aw_have | aw_take) & ~do_write;
    assign next_w_have  = (w_have | w_take) & ~do_write;
    assign next_bvalid  = (s_axi_bvalid & ~s_axi_bready) | do_write;
    assign ar_take      = s_axi_arvalid & s_axi_arready;
    assign next_rvalid  = (s_axi_rvalid & ~s_axi_rready) | ar_take;

    assign wsel_control = (aw_addr == A_CONTROL);
    assign wsel_wrap    = (aw_addr == A_WRAP);
    assign wsel_count   = (aw_addr == A_COUNT);
    assign wsel_evt     = (aw_addr == A_EVT);
    assign wsel_mask    = (aw_addr == A_MASK);
    // Read-only registers accept a write and ignore it.
    assign wsel_ro      = (aw_addr == A_LIVE) | (aw_addr == A_TRIG);
    assign wsel_ok      = wsel_control | wsel_wrap | wsel_count | wsel_evt | wsel_mask | wsel_ro;

    assign wr_control = merge(crw_pkg::DATA_W'(control), w_data, w_strb);
    assign wr_wrap    = merge(crw_pkg::DATA_W'(wrap_value), w_data, w_strb);
    assign wr_count   = merge(crw_pkg::DATA_W'(down_count), w_data, w_strb);
    assign wr_evt     = merge('0, w_data, w_strb);
    assign wr_mask    = merge(crw_pkg::DATA_W'(evt_mask), w_data, w_strb);

    assign rsel_ok = (s_axi_araddr == A_CONTROL) | (s_axi_araddr == A_LIVE) |
                     (s_axi_araddr == A_WRAP) | (s_axi_araddr == A_COUNT) |
                     (s_axi_araddr == A_TRIG) | (s_axi_araddr == A_EVT) |
                     (s_axi_araddr == A_MASK);
    assign rd_data = (s_axi_araddr == A_CONTROL) ? crw_pkg::DATA_W'(control) :
                     (s_axi_araddr == A_LIVE)    ? crw_pkg::DATA_W'(prescale) :
                     (s_axi_araddr == A_WRAP)    ? crw_pkg::DATA_W'(wrap_value) :
                     (s_axi_araddr == A_COUNT)   ? crw_pkg::DATA_W'(down_count) :
                     (s_axi_araddr == A_TRIG)    ? crw_pkg::DATA_W'(triggered) :
                     (s_axi_araddr == A_EVT)     ? crw_pkg::DATA_W'(evt_status) :
                     (s_axi_araddr == A_MASK)    ? crw_pkg::DATA_W'(evt_mask) : '0;

    // Bus handshake registers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= crw_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= crw_pkg::RESP_OKAY;
            s_axi_rdata   <= '0;
        end
        else
        begin
            aw_have       <= next_aw_have;
            w_have        <= next_w_have;
            s_axi_awready <= ~next_aw_have;
            s_axi_wready  <= ~next_w_have;
            s_axi_bvalid  <= next_bvalid;
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (do_write)
                s_axi_bresp <= wsel_ok ? crw_pkg::RESP_OKAY : crw_pkg::RESP_SLVERR;
            if (ar_take)
            begin
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rsel_ok ? crw_pkg::RESP_OKAY : crw_pkg::RESP_SLVERR;
            end
        end
    end

    // Payload capture; no reset needed since the have flags guard it.
    always_ff @(posedge aclk)
    begin
        if (aw_take)
            aw_addr <= s_axi_awaddr;
        if (w_take)
        begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
    end

    // Only the second stage of the synchroniser feeds the edge detector.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            xin_meta <= 1'b0;
            xin_sync <= 1'b0;
            xin_last <= 1'b0;
        end
        else
        begin
            xin_meta <= crystal_input;
            xin_sync <= xin_meta;
            xin_last <= xin_sync;
        end
    end

    assign xin_tick = xin_sync & ~xin_last;

    assign count_en = control[crw_pkg::CTRL_COUNT_EN];
    assign reset_en = control[crw_pkg::CTRL_RESET_EN];
    assign at_zero  = (down_count == '0);

    assign next_chip_reset = at_zero & count_en & reset_en;

    assign evt_set[crw_pkg::EVT_TIMEOUT] = at_zero & ~zero_last & count_en;
    assign evt_set[crw_pkg::EVT_WRAP]    = wrap_pulse;
    assign evt_clr         = (do_write & wsel_evt) ? wr_evt[crw_pkg::EVT_W-1:0] : '0;
    // A set in the same cycle as a clear wins.
    assign next_evt_status = (evt_status & ~evt_clr) | evt_set;

    // Control and configuration registers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            control    <= '0;
            wrap_value <= crw_pkg::WRAP_RESET[PRESCALE_W-1:0];
            evt_mask   <= '0;
        end
        else if (do_write)
        begin
            if (wsel_control)
                control <= wr_control[crw_pkg::CTRL_W-1:0];
            if (wsel_wrap)
                wrap_value <= wr_wrap[PRESCALE_W-1:0];
            if (wsel_mask)
                evt_mask <= wr_mask[crw_pkg::EVT_W-1:0];
        end
    end

    // Reset request, triggered flag and interrupt.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            chip_reset_out <= 1'b0;
            triggered      <= 1'b0;
            zero_last      <= 1'b0;
            evt_status     <= '0;
            irq            <= 1'b0;
        end
        else
        begin
            chip_reset_out <= next_chip_reset;
            triggered      <= triggered | next_chip_reset;
            zero_last      <= at_zero;
            evt_status     <= next_evt_status;
            irq            <= |(next_evt_status & evt_mask);
        end
    end

    crw_counter #(
        .PRESCALE_W (PRESCALE_W),
        .COUNT_W    (COUNT_W)
    ) u_counter (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .tick       (xin_tick),
        .count_en   (count_en),
        .wrap_value (wrap_value),
        .load       (do_write & wsel_count),
        .load_value (wr_count[COUNT_W-1:0]),
        .prescale   (prescale),
        .down_count (down_count),
        .wrap_pulse (wrap_pulse)
    );

endmodule

// [tb/crw_checker.sv]
/*
 * Port checker for the chip reset watchdog top.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module crw_checker (
    // Clock and reset.
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus.
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Outputs of interest.
    input wire logic        chip_reset_out,
    input wire logic        irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_reset_idle: assert property (disable iff (1'b0)
        !aresetn |=> !chip_reset_out && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active right after reset");
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready |-> ##[1:20] s_axi_bvalid)
        else $error("write not answered");
    a_aw_refused: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready while busy");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while data pending");
    a_read_resp: assert property (
        s_axi_rvalid && s_axi_rresp != crw_pkg::RESP_OKAY
        |-> s_axi_rresp == crw_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("bad read response");
    a_reset_fall: assert property (
        $fell(chip_reset_out) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("chip reset dropped without a write");
endmodule

bind crw_top crw_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .chip_reset_out(chip_reset_out), .irq(irq));

// [tb/crw_top_tb_top.sv]
/*
 * Self-checking bench for the chip reset watchdog top.
 * Assumes a 25 MHz clock and registers at byte address four times index.
 */
`timescale 1ns/1ps

module crw_top_tb_top;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, xtal;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, chip_rst, irq;
    int          errors, comparisons, cycles;
    localparam logic [1:0] OK = crw_pkg::RESP_OKAY;

    crw_top u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .crystal_input(xtal),
        .chip_reset_out(chip_rst), .irq(irq));

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic finish_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            $display("mismatch at %0t: run timed out", $time);
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
        check(bresp, er);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
        check(rdata, exp);
        check(rresp, er);
    endtask

    // Each pulse is one crystal rising edge, slow enough for the synchroniser.
    task automatic ticks(input int n);
        repeat (n)
        begin
            xtal <= 1'b1;
            repeat (4) @(posedge aclk);
            xtal <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, xtal} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check(chip_rst, 1'b0);
        rdc(crw_pkg::IDX_CONTROL, 32'h0, OK);
        rdc(crw_pkg::IDX_LIVE_COUNT, 32'h0, OK);
        rdc(crw_pkg::IDX_WRAP_VALUE, 32'hffff, OK);
        rdc(crw_pkg::IDX_DOWN_COUNT, 32'hfff, OK);
        rdc(crw_pkg::IDX_TRIGGERED, 32'h0, OK);
        rdc(crw_pkg::IDX_EVT_STATUS, 32'h0, OK);
        rdc(crw_pkg::IDX_EVT_MASK, 32'h0, OK);
        ticks(3);
        rdc(crw_pkg::IDX_LIVE_COUNT, 32'h0, OK);
        rdc(crw_pkg::IDX_DOWN_COUNT, 32'hfff, OK);
        // Wrap of 2 divides by three: seven edges leave the prescaler at 1.
        wr(crw_pkg::IDX_WRAP_VALUE, 32'h2, 4'hf, OK);
        wr(crw_pkg::IDX_DOWN_COUNT, 32'h5, 4'hf, OK);
        rdc(crw_pkg::IDX_DOWN_COUNT, 32'h5, OK);
        wr(crw_pkg::IDX_CONTROL, 32'h1, 4'hf, OK);
        ticks(7);
        rdc(crw_pkg::IDX_LIVE_COUNT, 32'h1, OK);
        rdc(crw_pkg::IDX_DOWN_COUNT, 32'h3, OK);
        wr(crw_pkg::IDX_CONTROL, 32'h0, 4'hf, OK);
        ticks(3);
        rdc(crw_pkg::IDX_LIVE_COUNT, 32'h1, OK);
        rdc(crw_pkg::IDX_DOWN_COUNT, 32'h3, OK);
        // Counting alone reaches zero without any chip reset; the prescaler wraps to 0.
        wr(crw_pkg::IDX_DOWN_COUNT, 32'h1, 4'hf, OK);
        wr(crw_pkg::IDX_CONTROL, 32'h1, 4'hf, OK);
        ticks(2);
        rdc(crw_pkg::IDX_DOWN_COUNT, 32'h0, OK);
        check(chip_rst, 1'b0);
        rdc(crw_pkg::IDX_TRIGGERED, 32'h0, OK);
        wr(crw_pkg::IDX_CONTROL, 32'h3, 4'hf, OK);
        repeat (3) @(posedge aclk);
        check(chip_rst, 1'b1);
        rdc(crw_pkg::IDX_TRIGGERED, 32'h1, OK);
        wr(crw_pkg::IDX_DOWN_COUNT, 32'h5, 4'hf, OK);
        repeat (3) @(posedge aclk);
        check(chip_rst, 1'b0);
        rdc(crw_pkg::IDX_TRIGGERED, 32'h1, OK);
        // Both events are pending; unmask the timeout event only, then clear it by writing a one.
        rdc(crw_pkg::IDX_EVT_STATUS, 32'h3, OK);
        check(irq, 1'b0);
        wr(crw_pkg::IDX_EVT_MASK, 32'h1, 4'hf, OK);
        repeat (3) @(posedge aclk);
        check(irq, 1'b1);
        wr(crw_pkg::IDX_EVT_STATUS, 32'h1, 4'hf, OK);
        repeat (3) @(posedge aclk);
        check(irq, 1'b0);
        rdc(crw_pkg::IDX_EVT_STATUS, 32'h2, OK);
        wr(crw_pkg::IDX_LIVE_COUNT, 32'h55, 4'hf, OK);
        rdc(crw_pkg::IDX_LIVE_COUNT, 32'h0, OK);
        wr(16'h0001, 32'h1, 4'hf, crw_pkg::RESP_SLVERR);
        rdc(16'h0001, 32'h0, crw_pkg::RESP_SLVERR);
        wr(crw_pkg::IDX_WRAP_VALUE, 32'h0000ab07, 4'h1, OK);
        rdc(crw_pkg::IDX_WRAP_VALUE, 32'h7, OK);
        finish_test();
    end
endmodule
